// File: logic/eid_defines.svh
// Purpose: offsets, field positions, reset values of the external pin interrupt block
// Assumes: APB byte addresses, one 32-bit aligned word per register
// Notes: register offsets chosen for this block
`ifndef EID_DEFINES_SVH
`define EID_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define EID_ADDR_W 4
`define EID_OFF_CTRL 4'h0
`define EID_OFF_ISTAT 4'h4
`define EID_OFF_IMASK 4'h8

// ****************************************
// control/status fields
// ****************************************
`define EID_BIT_PULL_DIS 6
`define EID_BIT_POL 5
`define EID_BIT_PIN_EN 4
`define EID_BIT_FLAG 3
`define EID_BIT_ACK 2
`define EID_BIT_IE 1
`define EID_BIT_MODE 0

// ****************************************
// reset values
// ****************************************
`define EID_CTRL_RST 8'h00
`define EID_ZERO32 32'h0000_0000

`endif

// File: logic/eid_extint.sv
// Purpose: external interrupt pin detect, flag, acknowledge and cpu request with apb access
// Assumes: apb master per protocol; pin asynchronous to pclk
// Notes: pull steering outputs drive the pad; zero wait state apb slave
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "eid_defines.svh"

// What this block does
// - With the pin enabled, bit 6 at 1 switches the pull resistor off and at 0 keeps it on.
// - Bit 5 picks falling/low sense at 0 and rising/high sense at 1.
// - With the pin enabled the pull is a pull-down for rising sense and a pull-up for falling.
// - Bit 4 turns the pin interrupt function on at 1 and off at 0.
// - Bit 3 is a read-only flag set on a qualifying event, 0 when nothing is pending.
// - Writing 1 to bit 2 clears the flag, writing 0 does nothing, and bit 2 reads 0.
// - In edge-and-level mode an acknowledge does not clear the flag while the pin is asserted.
// - With bit 1 set the cpu request follows the flag; with it clear no request is made.
// - Bit 0 selects edge-only detection at 0 and edge plus level at 1.
module eid_extint
  import eid_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`EID_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extint_pin,
  output logic pull_up_en,
  output logic pull_down_en,
  output logic cpu_irq,
  output logic sys_irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    eid_phase_t phase;
    logic pull_dis;
    logic pol;
    logic pin_en;
    logic flag;
    logic ie;
    logic mode;
    logic [1:0] settle;
    logic ev_stat;
    logic ev_mask;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic pu;
    logic pd;
    logic cpu_irq;
    logic sys_irq;
  } eid_state_t;

  eid_state_t st_ff;
  eid_state_t nxt_st;

  logic pin_cur;
  logic pin_prev;

  // ****************************************
  // pin synchroniser
  // ****************************************
  eid_pin_sync u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(extint_pin),
    .pin_cur(pin_cur),
    .pin_prev(pin_prev)
  );

  // ****************************************
  // combinational next state
  // ****************************************
  logic asserted;
  logic was_asserted;
  logic edge_ev;
  logic level_ev;
  logic event_hit;
  logic wr_acc;
  logic rd_setup;
  logic ack_req;
  logic ack_clear;
  logic [7:0] ctrl_view;
  logic [31:0] rd_word;
  logic mapped;
  logic [7:0] wb;
  logic [7:0] w1c;

  always_comb
  begin
    nxt_st = st_ff;
    // sense follows polarity bit
    asserted = st_ff.pol ? pin_cur : ~pin_cur;
    was_asserted = st_ff.pol ? pin_prev : ~pin_prev;
    // settle masks only the first cycle after enable, so a stale
    // sample pair never fakes an edge when the pin function is switched on
    edge_ev = st_ff.pin_en && (st_ff.settle == 2'd0) && asserted && !was_asserted;
    level_ev = st_ff.pin_en && (st_ff.settle == 2'd0) && st_ff.mode && asserted;
    event_hit = edge_ev || level_ev;

    mapped = (paddr == `EID_OFF_CTRL) || (paddr == `EID_OFF_ISTAT) ||
      (paddr == `EID_OFF_IMASK);
    wr_acc = psel && penable && pwrite && mapped;
    rd_setup = psel && !penable && !pwrite;
    wb = pstrb[0] ? pwdata[7:0] : 8'h00;

    // acknowledge only on write-one; held level blocks it in level mode
    ack_req = wr_acc && (paddr == `EID_OFF_CTRL) && wb[`EID_BIT_ACK];
    ack_clear = ack_req && !(st_ff.mode && st_ff.pin_en && asserted);

    // flag: a new event wins over a same-cycle acknowledge
    if (event_hit)
      nxt_st.flag = 1'b1;
    else if (ack_clear)
      nxt_st.flag = 1'b0;

    // control writes, low byte lane only
    if (wr_acc && (paddr == `EID_OFF_CTRL) && pstrb[0])
    begin
      nxt_st.pull_dis = pwdata[`EID_BIT_PULL_DIS];
      nxt_st.pol = pwdata[`EID_BIT_POL];
      nxt_st.pin_en = pwdata[`EID_BIT_PIN_EN];
      nxt_st.ie = pwdata[`EID_BIT_IE];
      nxt_st.mode = pwdata[`EID_BIT_MODE];
    end

    // settle counter restarts whenever the function is off
    if (!nxt_st.pin_en)
      nxt_st.settle = 2'd2;
    else if (st_ff.settle != 2'd0)
      nxt_st.settle = st_ff.settle - 2'd1;

    // sticky event status bit 0, write-one-to-clear; set wins
    w1c = (wr_acc && (paddr == `EID_OFF_ISTAT)) ? wb : 8'h00;
    if (event_hit)
      nxt_st.ev_stat = 1'b1;
    else if (w1c[0])
      nxt_st.ev_stat = 1'b0;
    if (wr_acc && (paddr == `EID_OFF_IMASK) && pstrb[0])
      nxt_st.ev_mask = pwdata[0];

    // read view; acknowledge bit always reads zero
    ctrl_view = 8'h00;
    ctrl_view[`EID_BIT_PULL_DIS] = st_ff.pull_dis;
    ctrl_view[`EID_BIT_POL] = st_ff.pol;
    ctrl_view[`EID_BIT_PIN_EN] = st_ff.pin_en;
    ctrl_view[`EID_BIT_FLAG] = st_ff.flag;
    ctrl_view[`EID_BIT_ACK] = 1'b0;
    ctrl_view[`EID_BIT_IE] = st_ff.ie;
    ctrl_view[`EID_BIT_MODE] = st_ff.mode;
    unique case (paddr)
      `EID_OFF_CTRL: rd_word = {24'h00_0000, ctrl_view};
      `EID_OFF_ISTAT: rd_word = {31'h0000_0000, st_ff.ev_stat};
      `EID_OFF_IMASK: rd_word = {31'h0000_0000, st_ff.ev_mask};
      default: rd_word = `EID_ZERO32;
    endcase

    // apb phases: data registered in setup so access has one wait-free cycle
    nxt_st.ready = 1'b0;
    nxt_st.slverr = 1'b0;
    unique case (st_ff.phase)
      EID_IDLE, EID_ACCESS:
      begin
        if (psel && !penable)
        begin
          nxt_st.phase = EID_SETUP;
          nxt_st.ready = 1'b1;
          nxt_st.slverr = !mapped;
          if (rd_setup)
            nxt_st.rdata = rd_word;
        end
        else
          nxt_st.phase = EID_IDLE;
      end
      EID_SETUP:
      begin
        nxt_st.phase = EID_ACCESS;
      end
      default:
      begin
        nxt_st.phase = EID_IDLE;
      end
    endcase

    // pull steering only while the pin function is on
    nxt_st.pu = nxt_st.pin_en && !nxt_st.pull_dis && !nxt_st.pol;
    nxt_st.pd = nxt_st.pin_en && !nxt_st.pull_dis && nxt_st.pol;
    // cpu request follows the flag when enabled
    nxt_st.cpu_irq = nxt_st.ie && nxt_st.flag;
    nxt_st.sys_irq = nxt_st.ev_stat && nxt_st.ev_mask;
  end

  // ****************************************
  // state register
  // ****************************************
  // everything clears, including control bits and flag, except settle which loads 2
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_ff <= '0;
      st_ff.phase <= EID_IDLE;
      st_ff.settle <= 2'd2;
    end
    else
      st_ff <= nxt_st;
  end

  // ****************************************
  // outputs, straight from flops
  // ****************************************
  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.slverr;
  assign pull_up_en = st_ff.pu;
  assign pull_down_en = st_ff.pd;
  assign cpu_irq = st_ff.cpu_irq;
  assign sys_irq = st_ff.sys_irq;

endmodule : eid_extint

// File: logic/eid_pin_sync.sv
// Purpose: two-flop synchroniser for the interrupt pin plus a sample stage
// Assumes: pin may change at any time
// Notes: only the second flop and later are looked at by the detector
`timescale 1ns/100ps
module eid_pin_sync
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  output logic pin_cur,
  output logic pin_prev
);

  typedef struct packed {
    logic meta;
    logic cur;
    logic prev;
  } eid_sync_t;

  eid_sync_t st_ff;
  eid_sync_t nxt_st;

  // shift chain; meta feeds cur only
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.meta = pin_in;
    nxt_st.cur = st_ff.meta;
    nxt_st.prev = st_ff.cur;
  end

  // reset to zero; detector masks the first samples after enable anyway
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign pin_cur = st_ff.cur;
  assign pin_prev = st_ff.prev;

endmodule : eid_pin_sync

// File: logic/eid_pkg.sv
// Purpose: types shared by the external pin interrupt block
// Assumes: nothing beyond the defines header
// Notes: access phases of the apb slave
package eid_pkg;

  // ****************************************
  // apb slave phase, gray along idle-setup-access
  // ****************************************
  typedef enum logic [1:0] {
    EID_IDLE = 2'b00,
    EID_SETUP = 2'b01,
    EID_ACCESS = 2'b11
  } eid_phase_t;

endpackage : eid_pkg

// File: test/eid_extint_sva.sv
// Purpose: port-level assertions for the external pin interrupt block
// Assumes: zero wait apb slave, outputs registered in the same stage as the control word
// Notes: two-cycle figures leave one cycle of margin over the single register stage
`timescale 1ns/100ps
`include "eid_defines.svh"
module eid_extint_sva
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`EID_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic extint_pin,
  input wire logic pull_up_en,
  input wire logic pull_down_en,
  input wire logic cpu_irq,
  input wire logic sys_irq
);
  logic cw;
  // ****************************************
  // control word write completing at this edge
  // ****************************************
  assign cw = psel && penable && pready && pwrite && paddr == `EID_OFF_CTRL && pstrb[0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  pull_excl_a:
    assert property (!(pull_up_en && pull_down_en)) else $error("both pulls on");
  pull_off_a:
    assert property (cw && (pwdata[6] || !pwdata[4]) |-> ##2 !pull_up_en && !pull_down_en)
    else $error("pull left on");
  pull_dn_a:
    assert property (cw && pwdata[4] && !pwdata[6] && pwdata[5] |-> ##2 pull_down_en)
    else $error("no pull-down");
  pull_up_a:
    assert property (cw && pwdata[4] && !pwdata[6] && !pwdata[5] |-> ##2 pull_up_en)
    else $error("no pull-up");
  irq_off_a:
    assert property (cw && !pwdata[1] |-> ##2 !cpu_irq) else $error("irq while disabled");
  ack_read_a:
    assert property (psel && penable && pready && !pwrite && paddr == `EID_OFF_CTRL |-> !prdata[2])
    else $error("ack bit read one");
  reset_out_a:
    assert property ($rose(presetn) |-> !cpu_irq && !pull_up_en && !pull_down_en)
    else $error("output set after reset");
  bus_ready_a:
    assert property (psel && !penable |=> pready) else $error("pready late");
  bus_err_a:
    assert property (psel && penable && pready && paddr == 4'hc |-> pslverr)
    else $error("no slave error");
endmodule : eid_extint_sva
bind eid_extint eid_extint_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .extint_pin(extint_pin),
  .pull_up_en(pull_up_en), .pull_down_en(pull_down_en), .cpu_irq(cpu_irq), .sys_irq(sys_irq));

// File: test/eid_pin_model.sv
// Purpose: outside source driving the interrupt pin
// Assumes: bench requests a level on lvl
// Notes: dly 0 answers at once, larger values model a slow source
`timescale 1ns/100ps
module eid_pin_model
(
  input wire logic pclk,
  input wire logic lvl,
  input wire logic [1:0] dly,
  output logic pin = 1'b0
);
  logic [1:0] cnt_ff = 2'h0;
  // follow the request after dly+1 edges so slow sources are seen too
  always @(posedge pclk)
  begin
    if (lvl == pin)
      cnt_ff <= 2'h0;
    else if (cnt_ff >= dly)
      pin <= lvl;
    else
      cnt_ff <= cnt_ff + 2'h1;
  end
endmodule : eid_pin_model

// File: test/test_external_pin_interrupt_detect.sv
// Purpose: self-checking bench for the external pin interrupt block
// Assumes: zero wait apb slave, pin model on extint_pin
// Notes: twelve-cycle pin waits cover sync stages plus model delay
`timescale 1ns/100ps
module test_external_pin_interrupt_detect;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic lvl = 0;
  logic [1:0] dly = 2'h0;
  logic [3:0] paddr = 4'h0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, pin, pull_up_en, pull_down_en, cpu_irq, sys_irq, err_s;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  always #2 pclk = ~pclk;
  eid_extint dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extint_pin(pin), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .cpu_irq(cpu_irq), .sys_irq(sys_irq));
  eid_pin_model pm (.pclk(pclk), .lvl(lvl), .dly(dly), .pin(pin));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", s, e, g);
      error_cnt++;
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [3:0] a, input logic [7:0] d,
    output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    // a slave that never answers counts as a mismatch
    if (pready !== 1'b1)
    begin
      $display("Error pready expected 1 seen %b", pready);
      error_cnt++;
    end
    r = prdata;
    err_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string s);
    logic [31:0] r;
    apb(1'b0, a, 8'h00, r);
    chk(s, e, r);
  endtask : rd
  task automatic drive(input logic v);
    lvl <= v;
    repeat (12) @(posedge pclk);
  endtask : drive
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_edge;
    wr(4'h0, 8'h32);
    chk("pull_down_en", 32'h0000_0001, pull_down_en);
    drive(1'b1);
    rd(4'h0, 32'h0000_003a, "rise flag");
    chk("cpu_irq", 32'h0000_0001, cpu_irq);
    wr(4'h0, 8'h36);
    rd(4'h0, 32'h0000_0032, "ack");
    wr(4'h0, 8'h30);
    drive(1'b0);
    drive(1'b1);
    rd(4'h0, 32'h0000_0038, "poll flag");
    chk("cpu_irq", 32'h0000_0000, cpu_irq);
  endtask : t_edge
  task automatic t_level;
    wr(4'h0, 8'h31);
    wr(4'h0, 8'h35);
    rd(4'h0, 32'h0000_0039, "level hold");
    drive(1'b0);
    wr(4'h0, 8'h35);
    rd(4'h0, 32'h0000_0031, "level ack");
  endtask : t_level
  task automatic t_fall;
    dly <= 2'h3;
    wr(4'h0, 8'h50);
    chk("pulls", 32'h0000_0000, {pull_up_en, pull_down_en});
    drive(1'b1);
    drive(1'b0);
    rd(4'h0, 32'h0000_0058, "fall flag");
    wr(4'h0, 8'h14);
    chk("pull_up_en", 32'h0000_0001, pull_up_en);
    rd(4'h0, 32'h0000_0010, "fall ack");
  endtask : t_fall
  task automatic t_off;
    wr(4'h0, 8'h00);
    drive(1'b1);
    drive(1'b0);
    rd(4'h0, 32'h0000_0000, "off flag");
    chk("pulls", 32'h0000_0000, {pull_up_en, pull_down_en});
  endtask : t_off
  task automatic t_sys;
    rd(4'h4, 32'h0000_0001, "status");
    chk("sys_irq", 32'h0000_0000, sys_irq);
    wr(4'h8, 8'h01);
    chk("sys_irq", 32'h0000_0001, sys_irq);
    wr(4'h4, 8'h01);
    chk("sys_irq", 32'h0000_0000, sys_irq);
    rd(4'h4, 32'h0000_0000, "status clear");
    rd(4'hc, 32'h0000_0000, "unmapped");
    chk("pslverr", 32'h0000_0001, err_s);
  endtask : t_sys
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // hang guard, far above the roughly 200 cycles the run needs
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(4'h0, 32'h0000_0000, "ctrl reset");
    t_edge();
    t_level();
    t_fall();
    t_off();
    t_sys();
    end_sim();
  end
endmodule : test_external_pin_interrupt_detect
